// >>> core/ptms_pkg.sv
// Constants and types for the page-translation mode select block.
// Assumes a 32-bit APB register port and a 52-bit physical address space.
package ptms_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_SYS_CTRL  = 8'h00;
  localparam logic [7:0] REG_FEAT_CTRL = 8'h04;
  localparam logic [7:0] REG_EXT_FEAT  = 8'h08;
  localparam logic [7:0] REG_TBASE_LO  = 8'h0c;
  localparam logic [7:0] REG_TBASE_HI  = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned TE_BIT        = 31;
  localparam int unsigned PAE_BIT       = 5;
  localparam int unsigned PSE_BIT       = 4;
  localparam int unsigned LME_BIT       = 8;
  localparam int unsigned LMA_BIT       = 10;
  localparam int unsigned DIR_LARGE_BIT = 7;
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_WIDE_BIT   = 1;
  localparam int unsigned ST_SIZE_LSB   = 2;
  localparam int unsigned ST_FAULT_BIT  = 4;
  localparam int unsigned ST_LMA_BIT    = 5;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic        CTRL_BIT_RST = 1'b0;
  localparam logic [51:0] TBASE_RST    = 52'h0;

  // ----------------------------------------------------------------------
  // Address geometry
  // ----------------------------------------------------------------------
  localparam int unsigned PA_W            = 52;
  localparam int unsigned PA_PSE_W        = 40;
  localparam int unsigned PA_LEG_W        = 32;
  localparam int unsigned VA_LONG_W       = 48;
  localparam int unsigned VA_LEG_W        = 32;
  localparam int unsigned IDX_BASE        = 12;
  localparam int unsigned IDX_WIDE_STEP   = 9;
  localparam int unsigned OFS_4K          = 12;
  localparam int unsigned OFS_2M          = 21;
  localparam int unsigned OFS_4M          = 22;
  localparam int unsigned OFS_1G          = 30;

  localparam logic [1:0] LVL_MAP4 = 2'h3;
  localparam logic [1:0] LVL_PTR  = 2'h2;
  localparam logic [1:0] LVL_DIR  = 2'h1;
  localparam logic [1:0] LVL_PT   = 2'h0;

  typedef enum logic [1:0] {
    PG_4K = 2'h0,
    PG_2M = 2'h1,
    PG_4M = 2'h2,
    PG_1G = 2'h3
  } ptms_page_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } ptms_state_t;

endpackage

// >>> core/ptms_mode_decode.sv
// Decodes the four translation controls into the translation form.
// Assumes all inputs are registered control bits of the same clock.
`timescale 1ns/1ps
module ptms_mode_decode (
  // Controls
  input  wire logic                te,
  input  wire logic                pae,
  input  wire logic                pse,
  input  wire logic                lma,
  // Resulting form
  output logic                     wide,
  output logic                     large_ok,
  output ptms_pkg::ptms_page_t     large_size,
  output logic [1:0]               top_level,
  output logic [5:0]               pa_limit
);

  always_comb begin
    wide       = pae;
    large_ok   = pae | pse | lma;
    large_size = ptms_pkg::PG_4K;
    top_level  = ptms_pkg::LVL_DIR;
    pa_limit   = 6'(ptms_pkg::PA_LEG_W);
    if (lma) begin
      large_size = ptms_pkg::PG_2M;
      top_level  = ptms_pkg::LVL_MAP4;
      pa_limit   = 6'(ptms_pkg::PA_W);
    end else if (pae) begin
      large_size = ptms_pkg::PG_2M;
      top_level  = ptms_pkg::LVL_PTR;
      pa_limit   = 6'(ptms_pkg::PA_W);
    end else if (pse) begin
      large_size = ptms_pkg::PG_4M;
      pa_limit   = 6'(ptms_pkg::PA_PSE_W);
    end
    if (!te) begin
      large_ok = 1'b0;
    end
  end

endmodule

// >>> core/ptms_entry_decode.sv
// Decodes one fetched table entry: final level or pointer to next table.
// Assumes the entry arrives in the low 32 bits when entries are narrow.
`timescale 1ns/1ps
module ptms_entry_decode (
  // Entry and context
  input  wire logic [63:0]         entry,
  input  wire logic [1:0]          level,
  input  wire logic                wide,
  input  wire logic                large_ok,
  input  wire ptms_pkg::ptms_page_t large_size,
  input  wire logic                lma,
  // Decode result
  output logic                     final_hit,
  output logic [51:0]              next_base,
  output ptms_pkg::ptms_page_t     page_size
);

  logic [51:0] tbl_base;
  logic        large_bit;

  always_comb begin
    tbl_base  = wide ? {entry[51:12], 12'h000}
                     : {20'h00000, entry[31:12], 12'h000};
    large_bit = entry[ptms_pkg::DIR_LARGE_BIT];
    final_hit = 1'b0;
    next_base = tbl_base;
    page_size = ptms_pkg::PG_4K;
    if (level == ptms_pkg::LVL_PT) begin
      final_hit = 1'b1;
    end else if (level == ptms_pkg::LVL_DIR && large_bit && large_ok) begin
      final_hit = 1'b1;
      page_size = large_size;
      if (large_size == ptms_pkg::PG_4M) begin
        next_base = {12'h000, entry[20:13], entry[31:22], 22'h000000};
      end else begin
        next_base = {entry[51:21], 21'h000000};
      end
    end else if (level == ptms_pkg::LVL_PTR && large_bit && lma) begin
      final_hit = 1'b1;
      page_size = ptms_pkg::PG_1G;
      next_base = {entry[51:30], 30'h00000000};
    end
  end

endmodule

// >>> core/ptms_core.sv
// Page-translation mode select with a table walker and APB registers.
// Assumes an APB master on pclk and a table memory that answers each
// fetch with a one-cycle fetch_ack carrying the entry.
//
// Contract
// - Long mode: 48-bit virtual to 52-bit physical
// - Form chosen only from four controls
// - Bit 31 of system control enables translation
// - Translation enable toggles long mode when enabled
// - Bit 5 of feature control enables extensions
// - Extensions: 64-bit entries, 52-bit addresses
// - Bit 4 permits large legacy pages
// - Page size decided per directory entry
// - Extensions on: large page is 2 Mbytes
// - No extensions, size ext: 4 Mbyte pages
// - Both off: only 4-Kbyte pages (the code still maps 2-Mbyte and 1-Gbyte pages while long mode is active)
// - Long mode ignores size ext bit
// - Legacy 4-Mbyte form yields 40-bit addresses
// - Legacy skips top level; pointer level conditional
// - Address split into indices plus byte offset
// - Entries chain down; last gives page base
// - Directory large bit ends walk at directory
// - Long-mode pointer large bit maps 1 Gbyte
`timescale 1ns/1ps
module ptms_core #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Translation request
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic [63:0]         req_vaddr,
  // Table fetch
  output logic                     fetch_valid,
  output logic [51:0]              fetch_addr,
  output logic                     fetch_wide,
  input  wire logic                fetch_ack,
  input  wire logic [63:0]         fetch_data,
  // Translation result
  output logic                     rsp_valid,
  output logic [51:0]              rsp_paddr,
  output ptms_pkg::ptms_page_t     rsp_size,
  output logic                     rsp_fault
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [51:0] entry_addr(
    input logic [51:0] base, input logic [1:0] lvl,
    input logic [63:0] va, input logic wd);
    logic [63:0] sh;
    logic [9:0]  idx;
    sh  = va >> (ptms_pkg::IDX_BASE + ptms_pkg::IDX_WIDE_STEP * lvl);
    idx = wd ? {1'b0, sh[8:0]} : (lvl == ptms_pkg::LVL_DIR ? va[31:22]
                                                           : va[21:12]);
    entry_addr = wd ? base + {39'h0, idx, 3'h0}
                    : base + {40'h0, idx, 2'h0};
  endfunction

  function automatic logic [51:0] width_mask(input logic [5:0] w);
    width_mask = (52'h1 << w) - 52'h1;
  endfunction

  function automatic logic [51:0] page_offset(
    input ptms_pkg::ptms_page_t sz, input logic [63:0] va);
    case (sz)
      ptms_pkg::PG_2M: page_offset = va[51:0] & width_mask(6'(ptms_pkg::OFS_2M));
      ptms_pkg::PG_4M: page_offset = va[51:0] & width_mask(6'(ptms_pkg::OFS_4M));
      ptms_pkg::PG_1G: page_offset = va[51:0] & width_mask(6'(ptms_pkg::OFS_1G));
      default:         page_offset = va[51:0] & width_mask(6'(ptms_pkg::OFS_4K));
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic        te_q, te_d, pae_q, pae_d, pse_q, pse_d;
  logic        lme_q, lme_d, lma_q, lma_d;
  logic [51:0] tbase_q, tbase_d;
  logic [31:0] prdata_q, prdata_d;
  logic        slverr_q, slverr_d;
  logic        wr_en, setup, known;

  ptms_pkg::ptms_state_t state_q, state_d;
  ptms_pkg::ptms_page_t  size_q, size_d;
  logic [63:0]           va_q, va_d;
  logic [1:0]            level_q, level_d;
  logic [51:0]           faddr_q, faddr_d;
  logic [51:0]           paddr_q, paddr_d;
  logic                  fault_q, fault_d;

  always_comb begin
    setup = psel && !penable;
    wr_en = psel && penable && pwrite;
    known = paddr == ADDR_W'(ptms_pkg::REG_SYS_CTRL)  ||
            paddr == ADDR_W'(ptms_pkg::REG_FEAT_CTRL) ||
            paddr == ADDR_W'(ptms_pkg::REG_EXT_FEAT)  ||
            paddr == ADDR_W'(ptms_pkg::REG_TBASE_LO)  ||
            paddr == ADDR_W'(ptms_pkg::REG_TBASE_HI)  ||
            paddr == ADDR_W'(ptms_pkg::REG_STATUS);
    te_d     = te_q;
    pae_d    = pae_q;
    pse_d    = pse_q;
    lme_d    = lme_q;
    lma_d    = lma_q;
    tbase_d  = tbase_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    if (setup) begin
      slverr_d = !known;
      prdata_d = 32'h0;
      case (paddr)
        ADDR_W'(ptms_pkg::REG_SYS_CTRL):  prdata_d[ptms_pkg::TE_BIT] = te_q;
        ADDR_W'(ptms_pkg::REG_FEAT_CTRL): begin
          prdata_d[ptms_pkg::PAE_BIT] = pae_q;
          prdata_d[ptms_pkg::PSE_BIT] = pse_q;
        end
        ADDR_W'(ptms_pkg::REG_EXT_FEAT): begin
          prdata_d[ptms_pkg::LME_BIT] = lme_q;
          prdata_d[ptms_pkg::LMA_BIT] = lma_q;
        end
        ADDR_W'(ptms_pkg::REG_TBASE_LO): prdata_d = tbase_q[31:0];
        ADDR_W'(ptms_pkg::REG_TBASE_HI): prdata_d = {12'h0, tbase_q[51:32]};
        ADDR_W'(ptms_pkg::REG_STATUS): begin
          prdata_d[ptms_pkg::ST_BUSY_BIT] = state_q != ptms_pkg::ST_IDLE;
          prdata_d[ptms_pkg::ST_WIDE_BIT] = pae_q;
          prdata_d[ptms_pkg::ST_SIZE_LSB +: 2] = size_q;
          prdata_d[ptms_pkg::ST_FAULT_BIT] = fault_q;
          prdata_d[ptms_pkg::ST_LMA_BIT] = lma_q;
        end
        default: prdata_d = 32'h0;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        ADDR_W'(ptms_pkg::REG_SYS_CTRL): begin
          te_d = pwdata[ptms_pkg::TE_BIT];
          // Long mode starts on a rising enable edge only while it is enabled; clearing enable always ends it
          if (lme_q && te_d && !te_q) begin
            lma_d = 1'b1;
          end else if (!te_d) begin
            lma_d = 1'b0;
          end
        end
        ADDR_W'(ptms_pkg::REG_FEAT_CTRL): begin
          pae_d = pwdata[ptms_pkg::PAE_BIT];
          pse_d = pwdata[ptms_pkg::PSE_BIT];
        end
        ADDR_W'(ptms_pkg::REG_EXT_FEAT): lme_d = pwdata[ptms_pkg::LME_BIT];
        ADDR_W'(ptms_pkg::REG_TBASE_LO): tbase_d[31:0] = {pwdata[31:3], 3'h0};
        ADDR_W'(ptms_pkg::REG_TBASE_HI): tbase_d[51:32] = pwdata[19:0];
        default: tbase_d = tbase_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      te_q     <= ptms_pkg::CTRL_BIT_RST;
      pae_q    <= ptms_pkg::CTRL_BIT_RST;
      pse_q    <= ptms_pkg::CTRL_BIT_RST;
      lme_q    <= ptms_pkg::CTRL_BIT_RST;
      lma_q    <= ptms_pkg::CTRL_BIT_RST;
      tbase_q  <= ptms_pkg::TBASE_RST;
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else begin
      te_q     <= te_d;
      pae_q    <= pae_d;
      pse_q    <= pse_d;
      lme_q    <= lme_d;
      lma_q    <= lma_d;
      tbase_q  <= tbase_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign pready  = psel && penable;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q;

  // ----------------------------------------------------------------------
  // Form decode
  // ----------------------------------------------------------------------
  logic                 wide, large_ok, final_hit;
  logic [1:0]           top_level;
  logic [5:0]           pa_limit;
  logic [51:0]          next_base;
  ptms_pkg::ptms_page_t large_size, ent_size;

  // Only the four controls reach the decoder
  ptms_mode_decode u_mode (
    .te         (te_q),
    .pae        (pae_q),
    .pse        (pse_q),
    .lma        (lma_q),
    .wide       (wide),
    .large_ok   (large_ok),
    .large_size (large_size),
    .top_level  (top_level),
    .pa_limit   (pa_limit)
  );

  // Each fetched entry decides its own page size
  ptms_entry_decode u_entry (
    .entry      (fetch_data),
    .level      (level_q),
    .wide       (wide),
    .large_ok   (large_ok),
    .large_size (large_size),
    .lma        (lma_q),
    .final_hit  (final_hit),
    .next_base  (next_base),
    .page_size  (ent_size)
  );

  // ----------------------------------------------------------------------
  // Table walker
  // ----------------------------------------------------------------------
  logic [63:0] va_in;
  logic        canon;

  always_comb begin
    // Long mode keeps all 64 bits, legacy keeps 32
    va_in = lma_q ? req_vaddr : {32'h0, req_vaddr[ptms_pkg::VA_LEG_W-1:0]};
    canon = &req_vaddr[63:ptms_pkg::VA_LONG_W-1] ||
            ~|req_vaddr[63:ptms_pkg::VA_LONG_W-1];
    state_d = state_q;
    va_d    = va_q;
    level_d = level_q;
    faddr_d = faddr_q;
    paddr_d = paddr_q;
    size_d  = size_q;
    fault_d = fault_q;
    case (state_q)
      ptms_pkg::ST_IDLE: begin
        if (req_valid) begin
          va_d    = va_in;
          fault_d = 1'b0;
          size_d  = ptms_pkg::PG_4K;
          if (!te_q) begin
            paddr_d = req_vaddr[51:0];
            state_d = ptms_pkg::ST_DONE;
          end else if (lma_q && !canon) begin
            // Full 64-bit translation is reserved
            paddr_d = 52'h0;
            fault_d = 1'b1;
            state_d = ptms_pkg::ST_DONE;
          end else begin
            level_d = top_level;
            faddr_d = entry_addr(tbase_q, top_level, va_in, wide);
            state_d = ptms_pkg::ST_FETCH;
          end
        end
      end
      ptms_pkg::ST_FETCH: begin
        if (fetch_ack) begin
          if (final_hit) begin
            size_d  = ent_size;
            // Base plus pass-through offset, cut to form width
            paddr_d = (next_base | page_offset(ent_size, va_q)) &
                      width_mask(pa_limit);
            state_d = ptms_pkg::ST_DONE;
          end else begin
            level_d = level_q - 2'h1;
            faddr_d = entry_addr(next_base, level_q - 2'h1, va_q, wide);
          end
        end
      end
      ptms_pkg::ST_DONE: state_d = ptms_pkg::ST_IDLE;
      default:           state_d = ptms_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ptms_pkg::ST_IDLE;
      va_q    <= 64'h0;
      level_q <= ptms_pkg::LVL_PT;
      faddr_q <= 52'h0;
      paddr_q <= 52'h0;
      size_q  <= ptms_pkg::PG_4K;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      va_q    <= va_d;
      level_q <= level_d;
      faddr_q <= faddr_d;
      paddr_q <= paddr_d;
      size_q  <= size_d;
      fault_q <= fault_d;
    end
  end

  assign req_ready   = state_q == ptms_pkg::ST_IDLE;
  assign fetch_valid = state_q == ptms_pkg::ST_FETCH;
  assign fetch_addr  = faddr_q;
  assign fetch_wide  = wide;
  assign rsp_valid   = state_q == ptms_pkg::ST_DONE;
  assign rsp_paddr   = paddr_q;
  assign rsp_size    = size_q;
  assign rsp_fault   = fault_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pass_through: assert property (
    req_valid && req_ready && !te_q |=> rsp_valid && !fetch_valid &&
      rsp_paddr == $past(req_vaddr[51:0]))
    else $error("untranslated address not passed through");
  a_enable_bit: assert property (
    wr_en && paddr == ADDR_W'(ptms_pkg::REG_SYS_CTRL) |=>
      te_q == $past(pwdata[ptms_pkg::TE_BIT]))
    else $error("translation enable not taken from bit 31");
  a_lma_clear: assert property (
    wr_en && paddr == ADDR_W'(ptms_pkg::REG_SYS_CTRL) &&
      !pwdata[ptms_pkg::TE_BIT] |=> !lma_q)
    else $error("long mode stayed active after enable cleared");
  a_entry_width: assert property (
    fetch_valid |-> fetch_wide == pae_q)
    else $error("entry width does not follow extensions");
  a_large_2m: assert property (
    rsp_valid && pae_q |-> rsp_size != ptms_pkg::PG_4M)
    else $error("4M page with extensions on");
  a_only_small: assert property (
    rsp_valid && !pae_q && !pse_q && !lma_q |-> rsp_size == ptms_pkg::PG_4K)
    else $error("large page with both extensions off");
  a_pa_40bit: assert property (
    rsp_valid && te_q && !pae_q && pse_q |-> rsp_paddr[51:40] == 12'h0)
    else $error("legacy 4M form exceeded 40 bits");
  a_legacy_top: assert property (
    fetch_valid && !lma_q |-> level_q != ptms_pkg::LVL_MAP4)
    else $error("legacy walk used the top level");
  a_long_sizes: assert property (
    rsp_valid && lma_q |-> rsp_size != ptms_pkg::PG_4M)
    else $error("4M page in long mode");
  a_noncanon: assert property (
    req_valid && req_ready && te_q && lma_q && !canon |=> rsp_valid && rsp_fault)
    else $error("non-canonical address not refused");

  c_passthru: cover property (req_valid && req_ready && !te_q ##1 rsp_valid);
  c_big_page: cover property (rsp_valid && rsp_size == ptms_pkg::PG_1G);
  c_four_meg: cover property (rsp_valid && rsp_size == ptms_pkg::PG_4M);
  c_long_walk: cover property (fetch_valid && level_q == ptms_pkg::LVL_MAP4);

endmodule

// >>> sim/ptms_mem.sv
// Table memory model that answers the walker's entry fetches.
// Assumes the bench fills mem by address before each walk.
`timescale 1ns/1ps
module ptms_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Fetch port
  input  wire logic        fetch_valid,
  input  wire logic [51:0] fetch_addr,
  input  wire logic        fetch_wide,
  output logic             fetch_ack,
  output logic [63:0]      fetch_data
);
  logic [63:0] mem [logic [51:0]];
  int          lat = 0;
  int          cnt;
  logic        hit;
  logic [63:0] m;
  // --------------------------------------------------------------------
  // Fetch answer, after lat idle cycles; noise on the bus otherwise
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ack  <= 1'b0;
      fetch_data <= 64'h0;
      cnt        <= 0;
    end else begin
      hit = (fetch_valid === 1'b1) && !fetch_ack && (cnt >= lat);
      m = mem.exists(fetch_addr) ? mem[fetch_addr] : ~fetch_data;
      fetch_ack  <= hit;
      fetch_data <= !hit ? ~fetch_data :
                    fetch_wide ? m : {~m[63:32], m[31:0]};
      cnt <= (fetch_valid === 1'b1 && !hit && !fetch_ack) ? cnt + 1 : 0;
    end
  end
endmodule

// >>> sim/page_translation_mode_select_bench.sv
// Self-checking bench for the translation mode select core.
// Assumes the table memory model ptms_mem on the fetch port.
`timescale 1ns/1ps
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module page_translation_mode_select_bench;
  typedef struct {logic [51:0] pa; logic [1:0] sz; logic f; logic c;}
    ptms_exp_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        req_valid = 0, pready, pslverr, req_ready, rsp_valid;
  logic        fetch_valid, fetch_wide, fetch_ack, rsp_fault;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [63:0] req_vaddr = 64'h0, fetch_data, va;
  logic [51:0] fetch_addr, rsp_paddr;
  logic [32:0] r;
  ptms_pkg::ptms_page_t rsp_size;
  ptms_exp_t   e;
  ptms_exp_t   tq[$];
  logic [32:0] rq[$];
  int          bad_count = 0, total_checks = 0, cyc = 0;
  int          seed = 32'h92d8102e;

  always #5 pclk = ~pclk;

  ptms_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .req_valid, .req_ready,
    .req_vaddr, .fetch_valid, .fetch_addr, .fetch_wide, .fetch_ack,
    .fetch_data, .rsp_valid, .rsp_paddr, .rsp_size, .rsp_fault);
  ptms_mem u_mem (.pclk, .presetn, .fetch_valid, .fetch_addr, .fetch_wide,
    .fetch_ack, .fetch_data);

  // --------------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) rq.push_back({err, d});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task tr(input logic [63:0] v, input logic [51:0] pa,
          input logic [1:0] sz, input logic f, input logic c);
    tq.push_back('{pa, sz, f, c});
    req_valid <= 1'b1;
    req_vaddr <= v;
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge pclk); while (rsp_valid !== 1'b1);
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Result monitor and hang guard
  // --------------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
    if (rsp_valid === 1'b1) begin
      e = tq.pop_front();
      `CHK("rsp_paddr", e.pa, rsp_paddr)
      `CHK("rsp_fault", e.f, rsp_fault)
      if (e.c) `CHK("rsp_size", e.sz, rsp_size)
    end
    if ((psel & penable & pready & ~pwrite) === 1'b1) begin
      r = rq.pop_front();
      `CHK("prdata", r[31:0], prdata)
      `CHK("pslverr", r[32], pslverr)
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ptms_pkg::REG_SYS_CTRL, 32'h0, 0);
    apb(0, 8'h20, 32'h0, 1);
    apb(1, ptms_pkg::REG_FEAT_CTRL, 32'hffff_ffff, 0);
    apb(0, ptms_pkg::REG_FEAT_CTRL, 32'h30, 0);
    apb(1, ptms_pkg::REG_TBASE_LO, 32'h1_0000, 0);
    apb(1, ptms_pkg::REG_TBASE_HI, 32'h0, 0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      va = {$random(seed), $random(seed)};
      tr(va, va[51:0], 2'h0, 1'b0, 1'b0);
    end
    $display("test pass-through done");
    apb(1, ptms_pkg::REG_FEAT_CTRL, 32'h0, 0);
    apb(1, ptms_pkg::REG_SYS_CTRL, 32'h8000_0000, 0);
    u_mem.mem[52'h10004] = 64'hffff_ffff_0002_0080;
    u_mem.mem[52'h2000c] = 64'hffff_ffff_0567_8000;
    u_mem.lat = 2;
    tr(64'hffff_ffff_0040_3abc, 52'h567_8abc, ptms_pkg::PG_4K, 0, 1);
    apb(1, ptms_pkg::REG_FEAT_CTRL, 32'h10, 0);
    u_mem.mem[52'h10004] = 64'hffff_ffff_c015_6080;
    u_mem.mem[52'h10008] = 64'hffff_ffff_0002_0000;
    tr(64'h0040_3abc, 52'hab_c000_3abc, ptms_pkg::PG_4M, 0, 1);
    tr(64'h0080_3abc, 52'h567_8abc, ptms_pkg::PG_4K, 0, 1);
    $display("test legacy done");
    apb(1, ptms_pkg::REG_FEAT_CTRL, 32'h30, 0);
    apb(1, ptms_pkg::REG_SYS_CTRL, 32'h0, 0);
    apb(1, ptms_pkg::REG_EXT_FEAT, 32'h100, 0);
    apb(1, ptms_pkg::REG_SYS_CTRL, 32'h8000_0000, 0);
    apb(0, ptms_pkg::REG_EXT_FEAT, 32'h500, 0);
    u_mem.mem[52'h10008] = 64'h3_0000;
    u_mem.mem[52'h30010] = 64'h4_0000;
    u_mem.mem[52'h40018] = 64'hf_ffff_ffe0_0080;
    u_mem.mem[52'h30028] = 64'h12_4000_0080;
    u_mem.lat = 0;
    tr(64'h80_8061_2345, 52'hf_ffff_ffe1_2345, ptms_pkg::PG_2M, 0, 1);
    tr(64'h81_4abc_def0, 52'h12_4abc_def0, ptms_pkg::PG_1G, 0, 1);
    tr(64'h8000_0000_0000, 52'h0, ptms_pkg::PG_4K, 1, 0);
    apb(1, ptms_pkg::REG_SYS_CTRL, 32'h0, 0);
    apb(0, ptms_pkg::REG_EXT_FEAT, 32'h100, 0);
    $display("test long mode done");
    end_sim();
  end
endmodule
